// File: logic/crf_regfile.sv
// CPU general register file, status word and stack pointer
`include "crf_consts.svh"
`default_nettype none
module crf_regfile #(
    parameter int BANK_CNT = `CRF_BANK_CNT,
    parameter int REG_CNT  = `CRF_REG_CNT
) (
    input  wire logic                clk,
    input  wire logic                rst,
    input  var  crf_pkg::crf_ref_t   rdRef,
    output var  logic [15:0]         rdData,
    input  wire logic                wrEn,
    input  var  crf_pkg::crf_ref_t   wrRef,
    input  wire logic [15:0]         wrData,
    input  wire logic                ramReq,
    input  wire logic                ramWr,
    input  wire logic                ramWord,
    input  wire logic [15:0]         ramAddr,
    input  wire logic [15:0]         ramWdata,
    output var  logic [15:0]         ramRdata,
    output var  logic                ramHit,
    input  var  crf_pkg::crf_alu_t   alu,
    input  wire logic                pswWrLo,
    input  wire logic                pswWrHi,
    input  wire logic [7:0]          pswWdata,
    input  wire logic                bitSet,
    input  wire logic                bitClr,
    input  wire logic [3:0]          bitIdx,
    input  var  crf_pkg::crf_bitop_t bitOp,
    input  wire logic                bitIn,
    input  wire logic                eiOp,
    input  wire logic                diOp,
    input  wire logic                irqAccept,
    input  wire logic                spLoad,
    input  wire logic [15:0]         spLdData,
    input  wire logic                spPush,
    input  wire logic                spPop,
    input  wire logic                spWord,
    output var  logic [15:0]         processor_status_word,
    output var  logic [15:0]         spOut,
    output var  logic                spValid
);
    import crf_pkg::*;

    // ----------------------------------------
    // Elaboration checks
    // ----------------------------------------
    // Offsets are bank:reg concatenations, so only 8 x 16 fits the window
    if (BANK_CNT != 8 || REG_CNT != 16) begin : g_bad_geometry
        $error("crf_regfile: only 8 banks of 16 registers are supported");
    end

    // ----------------------------------------
    // State
    // ----------------------------------------
    logic [7:0]  regMem [0:BANK_CNT*REG_CNT-1];
    logic        sgn_r, zro_r, hcy_r, pov_r, cy_r, ie_r, rss_r, uf_r;
    logic [2:0]  bank_r;
    logic [15:0] sp_r;
    logic        spValid_r;
    logic [15:0] rdData_r, ramRdata_r;
    logic        ramHit_r;
    logic [15:0] pswCur, pswNxt, spStep;
    logic        pswWrEn, ramIn;
    logic [6:0]  rdOff, wrOff, ramOff;
    crf_flags_t  flg;

    // ----------------------------------------
    // Name mapping and flag computation
    // ----------------------------------------
    crf_name_map u_rd_map (
        .register_set_select   (rss_r),
        .bank  (bank_r),
        .ref_i (rdRef),
        .off   (rdOff)
    );

    crf_name_map u_wr_map (
        .register_set_select   (rss_r),
        .bank  (bank_r),
        .ref_i (wrRef),
        .off   (wrOff)
    );

    crf_flag_calc u_flags (
        .alu (alu),
        .flg (flg)
    );

    // ----------------------------------------
    // Status word assembly and direct writes
    // ----------------------------------------
    // Unused status bits are tied to zero here, not stored
    assign pswCur = {uf_r, bank_r, 4'h0, sgn_r, zro_r, rss_r, hcy_r,
                     ie_r, pov_r, 1'b0, cy_r};
    assign pswWrEn = pswWrLo | pswWrHi | bitSet | bitClr;

    // Byte writes first, then single-bit set or clear on top
    always_comb begin
        pswNxt = pswCur;
        if (pswWrLo) begin
            pswNxt[7:0] = pswWdata;
        end
        if (pswWrHi) begin
            pswNxt[15:8] = pswWdata;
        end
        if (bitSet) begin
            pswNxt[bitIdx] = 1'b1;
        end
        if (bitClr) begin
            pswNxt[bitIdx] = 1'b0;
        end
    end

    // Mode bits: register set, bank field, user flag
    always_ff @(posedge clk) begin
        if (rst) begin
            rss_r  <= 1'b0;
            bank_r <= 3'b000;
            uf_r   <= 1'b0;
        end else if (pswWrEn) begin
            rss_r  <= pswNxt[`CRF_B_RSS];
            bank_r <= pswNxt[`CRF_B_BANK_HI:`CRF_B_BANK_LO];
            uf_r   <= pswNxt[`CRF_B_USER];
        end
    end

    // Condition flags; a direct status write beats the ALU in one cycle
    always_ff @(posedge clk) begin
        if (rst) begin
            {sgn_r, zro_r, hcy_r, pov_r, cy_r} <= 5'b00000;
        end else if (pswWrEn) begin
            sgn_r <= pswNxt[`CRF_B_SIGN];
            zro_r <= pswNxt[`CRF_B_ZERO];
            hcy_r <= pswNxt[`CRF_B_HALFCY];
            pov_r <= pswNxt[`CRF_B_PAROVF];
            cy_r  <= pswNxt[`CRF_B_CARRY];
        end else if (bitOp != BIT_NONE) begin
            case (bitOp)
                BIT_LD:  cy_r <= bitIn;
                BIT_AND: cy_r <= cy_r & bitIn;
                BIT_OR:  cy_r <= cy_r | bitIn;
                BIT_XOR: cy_r <= cy_r ^ bitIn;
                BIT_NOT: cy_r <= ~cy_r;
                default: cy_r <= cy_r;
            endcase
        end else if (alu.valid) begin
            sgn_r <= flg.s;
            zro_r <= flg.z;
            hcy_r <= flg.ac;
            pov_r <= flg.pv;
            cy_r  <= flg.cy;
        end
    end

    // Interrupt enable; an accepted interrupt outranks a same-cycle unmask
    always_ff @(posedge clk) begin
        if (rst) begin
            ie_r <= 1'b0;
        end else if (diOp || irqAccept) begin
            ie_r <= 1'b0;
        end else if (eiOp) begin
            ie_r <= 1'b1;
        end else if (pswWrEn) begin
            ie_r <= pswNxt[`CRF_B_IRQEN];
        end
    end

    assign processor_status_word = pswCur;

    // ----------------------------------------
    // Stack pointer
    // ----------------------------------------
    assign spStep = spWord ? `CRF_STEP_WORD : `CRF_STEP_BYTE;

    // No reset on purpose: the pointer is garbage until software loads it
    always_ff @(posedge clk) begin
        if (spLoad) begin
            sp_r <= spLdData;
        end else if (spPush) begin
            sp_r <= sp_r - spStep;
        end else if (spPop) begin
            sp_r <= sp_r + spStep;
        end
    end

    // Tells the core whether the pointer has been loaded since reset
    always_ff @(posedge clk) begin
        if (rst) begin
            spValid_r <= 1'b0;
        end else if (spLoad) begin
            spValid_r <= 1'b1;
        end
    end

    assign spOut   = sp_r;
    assign spValid = spValid_r;

    // ----------------------------------------
    // Register RAM
    // ----------------------------------------
    // Memory bus sees the same bytes; word accesses drop bit 0
    assign ramIn  = ramReq && (ramAddr[15:7] == `CRF_RAM_PAGE);
    assign ramOff = ramWord ? {ramAddr[6:1], 1'b0} : ramAddr[6:0];

    // Register port write lands after the memory bus, so it wins a clash
    always_ff @(posedge clk) begin
        if (ramIn && ramWr) begin
            regMem[ramOff] <= ramWdata[7:0];
            if (ramWord) begin
                regMem[ramOff + 7'd1] <= ramWdata[15:8];
            end
        end
        if (wrEn) begin
            regMem[wrOff] <= wrData[7:0];
            if (wrRef.isPair) begin
                regMem[wrOff + 7'd1] <= wrData[15:8];
            end
        end
    end

    // Register read port, one cycle of latency
    always_ff @(posedge clk) begin
        if (rst) begin
            rdData_r <= 16'h0000;
        end else if (rdRef.isPair) begin
            rdData_r <= {regMem[rdOff + 7'd1], regMem[rdOff]};
        end else begin
            rdData_r <= {8'h00, regMem[rdOff]};
        end
    end

    // Memory bus read port; a miss reads zero
    always_ff @(posedge clk) begin
        if (rst) begin
            ramRdata_r <= 16'h0000;
            ramHit_r   <= 1'b0;
        end else begin
            ramHit_r   <= ramIn;
            ramRdata_r <= 16'h0000;
            if (ramIn && !ramWr) begin
                ramRdata_r <= ramWord ? {regMem[ramOff + 7'd1], regMem[ramOff]}
                                      : {8'h00, regMem[ramOff]};
            end
        end
    end

    assign rdData   = rdData_r;
    assign ramRdata = ramRdata_r;
    assign ramHit   = ramHit_r;

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    logic [4:0] hcSum;
    assign hcSum = alu.sub ? ({1'b0, alu.a[3:0]} - {1'b0, alu.b[3:0]} - {4'h0, alu.cin})
                           : ({1'b0, alu.a[3:0]} + {1'b0, alu.b[3:0]} + {4'h0, alu.cin});

    sequence sAluOnly;
        alu.valid && !pswWrEn && bitOp == BIT_NONE;
    endsequence

    sequence sPush;
        spPush && !spLoad;
    endsequence

    sequence sPop;
        spPop && !spPush && !spLoad;
    endsequence

    a_rss_zero_map: assert property (!rdRef.isPair && rdRef.isFunc && rdRef.idx == 4'h1
        && !rss_r |-> rdOff == {bank_r, 4'h1})
        else $error("function A not mapped to R1 with set bit 0");

    a_rss_one_map: assert property (rdRef.isPair && rdRef.isFunc && rdRef.idx == 4'h1
        && rss_r |-> rdOff == {bank_r, 4'h6})
        else $error("counter pair not mapped to RP3 with set bit 1");

    a_abs_reach: assert property (!rdRef.isPair && !rdRef.isFunc
        |-> rdOff == {bank_r, rdRef.idx})
        else $error("absolute register number remapped");

    a_rss_bit_set: assert property (bitSet && !bitClr && bitIdx == 4'd5
        |=> rss_r && processor_status_word[5])
        else $error("set bit did not reach status bit 5");

    a_half_carry: assert property (sAluOnly and (alu.arith == 1'b1)
        |=> hcy_r == $past(hcSum[4]))
        else $error("half carry wrong after arithmetic op");

    a_irq_clear: assert property ((diOp || irqAccept) |=> !ie_r ##1 (!ie_r || $past(eiOp)
        || $past(pswWrEn)))
        else $error("interrupt enable not cleared or set without cause");

    a_parity_low: assert property (sAluOnly and (alu.arith == 1'b0)
        |=> pov_r == ~^$past(alu.res[7:0]))
        else $error("parity flag not from low result byte");

    a_overflow_add: assert property (sAluOnly and (alu.arith && !alu.word && !alu.sub
        && alu.a[7:0] == 8'h78 && alu.b[7:0] == 8'h69 && !alu.cin) |=> pov_r && !cy_r)
        else $error("overflow flag wrong for byte add");

    a_carry_word: assert property (sAluOnly and (alu.arith && alu.word && !alu.sub)
        |=> cy_r == (({1'b0, $past(alu.a)} + {1'b0, $past(alu.b)}
        + {16'h0000, $past(alu.cin)}) > 17'h0FFFF))
        else $error("word carry flag wrong");

    a_sp_push_pop: assert property ((sPush |=> sp_r == $past(sp_r) - $past(spStep))
        and (sPop |=> sp_r == $past(sp_r) + $past(spStep)))
        else $error("stack pointer step wrong");

    a_psw_reset: assert property (@(posedge clk) disable iff (1'b0)
        rst |=> processor_status_word == `CRF_PSW_RST)
        else $error("status word not cleared by reset");

endmodule // crf_regfile
`default_nettype wire

// File: logic/crf_consts.svh
// Constants for the CPU register file and status word block
`ifndef CRF_CONSTS_SVH
`define CRF_CONSTS_SVH

// ----------------------------------------
// General register window in internal RAM
// ----------------------------------------
`define CRF_RAM_BASE    16'hFE80
`define CRF_RAM_LAST    16'hFEFF
`define CRF_RAM_PAGE    9'h01FD
`define CRF_BANK_CNT    8
`define CRF_REG_CNT     16

// ----------------------------------------
// Status word bit positions
// ----------------------------------------
`define CRF_B_CARRY     0
`define CRF_B_PAROVF    2
`define CRF_B_IRQEN     3
`define CRF_B_HALFCY    4
`define CRF_B_RSS       5
`define CRF_B_ZERO      6
`define CRF_B_SIGN      7
`define CRF_B_BANK_LO   12
`define CRF_B_BANK_HI   14
`define CRF_B_USER      15

// ----------------------------------------
// Reset values and steps
// ----------------------------------------
`define CRF_PSW_RST     16'h0000
`define CRF_STEP_BYTE   16'h0001
`define CRF_STEP_WORD   16'h0002

`endif

// File: logic/crf_pkg.sv
// Types shared by the register file and status word modules
`default_nettype none
package crf_pkg;

    // Register reference: absolute number or function name
    typedef struct packed {
        logic       isPair;
        logic       isFunc;
        logic [3:0] idx;
    } crf_ref_t;

    // One ALU operation as seen by the flag logic
    typedef struct packed {
        logic        valid;
        logic        arith;
        logic        word;
        logic        sub;
        logic        cin;
        logic [15:0] a;
        logic [15:0] b;
        logic [15:0] res;
    } crf_alu_t;

    // Condition flags produced by one operation
    typedef struct packed {
        logic s;
        logic z;
        logic ac;
        logic pv;
        logic cy;
    } crf_flags_t;

    // Operations on the one-bit accumulator
    typedef enum logic [2:0] {
        BIT_NONE,
        BIT_LD,
        BIT_AND,
        BIT_OR,
        BIT_XOR,
        BIT_NOT
    } crf_bitop_t;

endpackage
`default_nettype wire

// File: logic/crf_name_map.sv
// Maps a register reference to its byte offset in the register RAM
`default_nettype none
module crf_name_map (
    input  wire logic              register_set_select,
    input  wire logic [2:0]        bank,
    input  var  crf_pkg::crf_ref_t ref_i,
    output var  logic [6:0]        off
);
    import crf_pkg::*;

    logic [2:0] pairIdx;
    logic [3:0] byteIdx;

    // Function names 0-3 and pairs 0-1 follow the set bit, absolute names never do
    always_comb begin
        pairIdx = ref_i.idx[2:0];
        byteIdx = ref_i.idx;
        if (ref_i.isPair) begin
            if (ref_i.isFunc && ref_i.idx[3:1] == 3'b000) begin
                pairIdx = {1'b0, register_set_select, ref_i.idx[0]};
            end
            byteIdx = {pairIdx, 1'b0};
        end else if (ref_i.isFunc && ref_i.idx[3:2] == 2'b00) begin
            byteIdx = {1'b0, register_set_select, ref_i.idx[1:0]};
        end
        off = {bank, byteIdx};
    end

endmodule // crf_name_map
`default_nettype wire

// File: logic/crf_flag_calc.sv
// Computes condition flags for one arithmetic or logical operation
`default_nettype none
module crf_flag_calc (
    input  var crf_pkg::crf_alu_t   alu,
    output var crf_pkg::crf_flags_t flg
);
    import crf_pkg::*;

    logic [16:0] w17;
    logic [8:0]  w9;
    logic [4:0]  w5;
    logic [15:0] r;
    logic        ma, mb, mr;

    // Carries come from widened sums so borrow shows as the top bit
    always_comb begin
        if (alu.sub) begin
            w17 = {1'b0, alu.a} - {1'b0, alu.b} - {16'h0000, alu.cin};
            w9  = {1'b0, alu.a[7:0]} - {1'b0, alu.b[7:0]} - {8'h00, alu.cin};
            w5  = {1'b0, alu.a[3:0]} - {1'b0, alu.b[3:0]} - {4'h0, alu.cin};
        end else begin
            w17 = {1'b0, alu.a} + {1'b0, alu.b} + {16'h0000, alu.cin};
            w9  = {1'b0, alu.a[7:0]} + {1'b0, alu.b[7:0]} + {8'h00, alu.cin};
            w5  = {1'b0, alu.a[3:0]} + {1'b0, alu.b[3:0]} + {4'h0, alu.cin};
        end
        r  = alu.arith ? (alu.word ? w17[15:0] : {8'h00, w9[7:0]}) : alu.res;
        ma = alu.word ? alu.a[15] : alu.a[7];
        mb = (alu.word ? alu.b[15] : alu.b[7]) ^ alu.sub;
        mr = alu.word ? r[15] : r[7];
        flg.s  = mr;
        flg.z  = alu.word ? (r == 16'h0000) : (r[7:0] == 8'h00);
        flg.ac = alu.arith & w5[4];
        if (alu.arith) begin
            flg.pv = (ma == mb) && (mr != ma);
        end else begin
            flg.pv = ~^r[7:0];
        end
        flg.cy = alu.arith & (alu.word ? w17[16] : w9[8]);
    end

endmodule // crf_flag_calc
`default_nettype wire

// File: dv/crf_alu_model.sv
// Behavioural model of the decoder and ALU side that feeds the flag logic
`default_nettype none
module crf_alu_model (
    input  wire logic              go,
    input  wire logic              arith,
    input  wire logic              word,
    input  wire logic              sub,
    input  wire logic              cin,
    input  wire logic [1:0]        kind,
    input  wire logic [15:0]       opA,
    input  wire logic [15:0]       opB,
    output var  crf_pkg::crf_alu_t alu
);
    timeunit 1ns;
    timeprecision 1ns;
    import crf_pkg::*;
    logic [15:0] res;
    // The real adder result is sent too, though the block redoes arithmetic itself
    always_comb begin
        if (arith) begin
            res = sub ? opA - opB - 16'(cin) : opA + opB + 16'(cin);
        end else begin
            res = kind == 2'h0 ? opA & opB : kind == 2'h1 ? opA | opB : opA ^ opB;
        end
        // Byte results keep a clean upper byte, as a byte ALU would leave it
        if (!word) begin
            res[15:8] = 8'h00;
        end
        alu = {go, arith, word, sub, cin, opA, opB, res};
    end
endmodule // crf_alu_model
`default_nettype wire

// File: dv/crf_regfile_bench.sv
// Self-checking bench for the register file, status word and stack pointer
`default_nettype none
`define CMP(g, e) begin comparisons++; if ((g) !== (e)) begin failures++; \
    $display("[ERR] t=%0t got=%h exp=%h", $time, g, e); end end
module crf_regfile_bench;
    timeunit 1ns;
    timeprecision 1ns;
    import crf_pkg::*;
    typedef struct packed {
        crf_ref_t    rdRef, wrRef;
        logic        wrEn, ramReq, ramWr, ramWord, aluGo, aluArith, aluWord, aluSub, aluCin;
        logic [15:0] wrData, ramAddr, ramWdata, aluA, aluB, spLdData;
        logic [1:0]  aluKind;
        logic        pswWrLo, pswWrHi, bitSet, bitClr, bitIn, eiOp, diOp, irqAccept;
        logic [7:0]  pswWdata;
        logic [3:0]  bitIdx;
        crf_bitop_t  bitOp;
        logic        spLoad, spPush, spPop, spWord;
    } crf_stim_t;
    typedef struct {
        int          w;
        logic [15:0] e, m;
        time         t;
    } crf_note_t;
    logic        clk, rst, ramHit, spValid;
    crf_stim_t   st, s0, s;
    crf_alu_t    aluBus;
    logic [15:0] rdData, ramRdata, processor_status_word, spOut, got, pswM;
    logic [7:0]  regs [16];
    logic [15:0] spExp [4] = '{16'hFE3E, 16'hFE3D, 16'hFE3E, 16'hFE40};
    crf_note_t   notes [$];
    crf_note_t   n;
    int          failures, comparisons, seed;

    crf_alu_model alu_u (.go(st.aluGo), .arith(st.aluArith), .word(st.aluWord),
        .sub(st.aluSub), .cin(st.aluCin), .kind(st.aluKind), .opA(st.aluA), .opB(st.aluB),
        .alu(aluBus));
    crf_regfile dut_u (.clk(clk), .rst(rst), .rdRef(st.rdRef), .rdData(rdData),
        .wrEn(st.wrEn), .wrRef(st.wrRef), .wrData(st.wrData), .ramReq(st.ramReq),
        .ramWr(st.ramWr), .ramWord(st.ramWord), .ramAddr(st.ramAddr),
        .ramWdata(st.ramWdata), .ramRdata(ramRdata), .ramHit(ramHit), .alu(aluBus),
        .pswWrLo(st.pswWrLo), .pswWrHi(st.pswWrHi), .pswWdata(st.pswWdata),
        .bitSet(st.bitSet), .bitClr(st.bitClr), .bitIdx(st.bitIdx), .bitOp(st.bitOp),
        .bitIn(st.bitIn), .eiOp(st.eiOp), .diOp(st.diOp), .irqAccept(st.irqAccept),
        .spLoad(st.spLoad), .spLdData(st.spLdData), .spPush(st.spPush), .spPop(st.spPop),
        .spWord(st.spWord), .processor_status_word(processor_status_word), .spOut(spOut), .spValid(spValid));

    // Clock at 10 MHz
    initial clk = 1'b0;
    always #50 clk = ~clk;

    function automatic logic [15:0] obs(input int w);
        case (w)
            0: return processor_status_word;
            1: return rdData;
            2: return ramRdata;
            3: return {15'h0000, ramHit};
            4: return spOut;
            default: return {15'h0000, spValid};
        endcase
    endfunction

    // Every answer lands one edge after launch; look just after that edge settles
    always @(posedge clk) begin
        #1;
        while (notes.size() > 0 && notes[0].t < $time) begin
            n = notes.pop_front();
            got = obs(n.w);
            `CMP(got & n.m, n.e & n.m)
        end
    end

    task automatic drive(input crf_stim_t d);
        @(posedge clk);
        st <= d;
    endtask
    task automatic note(input int w, input logic [15:0] e, input logic [15:0] m = 16'hFFFF);
        notes.push_back('{w, e, m, $time + 100});
    endtask
    task automatic testEnd(input string t);
        $display("test %s done", t);
    endtask
    task automatic rd(input crf_ref_t r, input logic [15:0] e);
        crf_stim_t x;
        x = s0;
        x.rdRef = r;
        drive(x);
        note(1, e);
    endtask
    task automatic pswOp(input crf_stim_t x, input logic [15:0] e);
        drive(x);
        pswM = e;
        note(0, e);
    endtask
    task automatic ram(input logic wr, wd, input logic [15:0] ad, wdat, e, input logic hit);
        crf_stim_t x;
        x = s0;
        {x.ramReq, x.ramWr, x.ramWord, x.ramAddr, x.ramWdata} = {1'b1, wr, wd, ad, wdat};
        drive(x);
        note(2, e);
        note(3, {15'h0000, hit});
    endtask
    // Flags worked out independently; byte operands carry a clear upper byte
    task automatic aluChk(input logic ar, wd, sb, ci, input logic [1:0] k,
                          input logic [15:0] a, b);
        crf_stim_t   x;
        logic [16:0] f;
        logic [15:0] r;
        logic        sa, sbb, sr, v;
        x = s0;
        if (!wd) begin
            a[15:8] = 8'h00;
            b[15:8] = 8'h00;
        end
        if (ar) f = sb ? {1'b0, a} - {1'b0, b} - 17'(ci) : {1'b0, a} + {1'b0, b} + 17'(ci);
        else f = {1'b0, k == 2'h0 ? a & b : k == 2'h1 ? a | b : a ^ b};
        r = f[15:0];
        sa = wd ? a[15] : a[7];
        sbb = (wd ? b[15] : b[7]) ^ sb;
        sr = wd ? r[15] : r[7];
        v = ar ? (sa == sbb) && (sr != sa) : ~^r[7:0];
        {x.aluGo, x.aluArith, x.aluWord, x.aluSub, x.aluCin} = {1'b1, ar, wd, sb, ci};
        {x.aluKind, x.aluA, x.aluB} = {k, a, b};
        pswOp(x, {pswM[15:8], sr, (wd ? r : {8'h00, r[7:0]}) == 16'h0000, pswM[5],
                  ar & (a[4] ^ b[4] ^ r[4]), pswM[3], v, 1'b0, ar & (wd ? f[16] : f[8])});
    endtask

    task automatic print_verdict();
        $display("comparisons=%0d failures=%0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // Guard against a hung run
    initial begin
        repeat (5000) @(posedge clk);
        failures++;
        print_verdict();
    end

    // Main sequence
    initial begin
        seed = 9042;
        rst = 1'b1;
        s0 = '0;
        st = '0;
        pswM = 16'h0000;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        drive(s0);
        note(0, 16'h0000);
        note(5, 16'h0000);
        for (int i = 0; i < 16; i++) begin
            s = s0;
            s.wrEn = 1'b1;
            s.wrRef = '{1'b0, 1'b0, 4'(i)};
            regs[i] = 8'($random(seed));
            s.wrData = {8'h00, regs[i]};
            drive(s);
        end
        testEnd("reset and fill");
        // Names follow the set bit, absolute names never move
        for (int m = 0; m < 2; m++) begin
            for (int i = 0; i < 4; i++) rd('{1'b0, 1'b1, 4'(i)}, {8'h00, regs[4*m+i]});
            for (int i = 0; i < 2; i++) rd('{1'b1, 1'b1, 4'(i)}, {regs[4*m+2*i+1], regs[4*m+2*i]});
            for (int i = 0; i < 8; i++) rd('{1'b0, 1'b0, 4'(i)}, {8'h00, regs[i]});
            for (int i = 0; i < 8; i++) rd('{1'b1, 1'b0, 4'(i)}, {regs[2*i+1], regs[2*i]});
            s = s0;
            s.bitSet = m == 0;
            s.bitClr = m == 1;
            s.bitIdx = 4'h5;
            pswOp(s, {10'h000, m == 0, 5'h00});
        end
        testEnd("names");
        s = s0;
        s.pswWrHi = 1'b1;
        s.pswWdata = 8'h30;
        pswOp(s, 16'h3000);
        s = s0;
        s.wrEn = 1'b1;
        s.wrRef = '{1'b0, 1'b1, 4'h2};
        s.wrData = 16'h00C3;
        drive(s);
        ram(1'b0, 1'b0, 16'hFEB2, 16'h0000, 16'h00C3, 1'b1);
        ram(1'b0, 1'b0, 16'hFE82, 16'h0000, {8'h00, regs[2]}, 1'b1);
        ram(1'b0, 1'b1, 16'hFE88, 16'h0000, {regs[9], regs[8]}, 1'b1);
        ram(1'b1, 1'b0, 16'hFEFF, 16'h005A, 16'h0000, 1'b1);
        ram(1'b0, 1'b0, 16'hFEFF, 16'h0000, 16'h005A, 1'b1);
        ram(1'b0, 1'b0, 16'hFE7F, 16'h0000, 16'h0000, 1'b0);
        testEnd("banks");
        s = s0;
        s.pswWrLo = 1'b1;
        s.pswWdata = 8'hFF;
        pswOp(s, 16'h30FD);
        s.pswWdata = 8'h00;
        pswOp(s, 16'h3000);
        // A clear of the enable beats a same-cycle set
        for (int i = 0; i < 5; i++) begin
            s = s0;
            s.eiOp = i != 1 && i != 3;
            s.diOp = i == 1 || i == 4;
            s.irqAccept = i == 3;
            pswOp(s, {pswM[15:4], i == 0 || i == 2, pswM[2:0]});
        end
        for (int i = 0; i < 5; i++) begin
            s = s0;
            s.bitOp = crf_bitop_t'(i + 1);
            s.bitIn = 1'(5'h0D >> i);
            pswOp(s, {pswM[15:1], 1'(5'h15 >> i)});
        end
        testEnd("status");
        aluChk(1'b1, 1'b0, 1'b0, 1'b0, 2'h0, 16'h0078, 16'h0069);
        aluChk(1'b1, 1'b0, 1'b1, 1'b0, 2'h0, 16'h0055, 16'h0055);
        aluChk(1'b1, 1'b1, 1'b0, 1'b0, 2'h0, 16'hFFFF, 16'h0001);
        for (int i = 0; i < 15; i++) begin
            aluChk(i < 6, i % 3 == 0, i % 2 == 1, i == 4, 2'(i % 3), 16'($random(seed)),
                   16'($random(seed)));
        end
        testEnd("flags");
        s = s0;
        s.spLoad = 1'b1;
        s.spLdData = 16'hFE40;
        drive(s);
        note(4, 16'hFE40);
        note(5, 16'h0001);
        for (int i = 0; i < 4; i++) begin
            s = s0;
            s.spPush = i < 2;
            s.spPop = i >= 2;
            s.spWord = i == 0 || i == 3;
            drive(s);
            note(4, spExp[i]);
        end
        drive(s0);
        repeat (2) @(posedge clk);
        #2;
        testEnd("stack");
        if (notes.size() != 0) failures++;
        print_verdict();
    end
endmodule // crf_regfile_bench
`default_nettype wire
